// ### hw/dcdsi_consts.svh
// constants for the dual-channel ddr sample input block
// assumes inclusion by bare name from the top module and the testbench
`ifndef DCDSI_CONSTS_SVH
`define DCDSI_CONSTS_SVH

`define DCDSI_OFF_CONFIG   8'h00
`define DCDSI_OFF_STATUS   8'h04
`define DCDSI_OFF_PAIR     8'h08
`define DCDSI_OFF_COUNT    8'h0C

`define DCDSI_BIT_REVERSE  0
`define DCDSI_BIT_FOURWIRE 9

`define DCDSI_CONFIG_RESET 32'h0000_0000
`define DCDSI_CONFIG_MASK  32'h0000_0201

`define DCDSI_ST_GATE      0
`define DCDSI_ST_SLEEP     1
`define DCDSI_ST_FOURWIRE  2

`define DCDSI_RESP_OKAY    2'h0
`define DCDSI_RESP_SLVERR  2'h2

`define DCDSI_SYNC_STAGES  2

`endif

// ### hw/dcdsi_pkg.sv
// types shared by the sample input block
// assumes nothing beyond a sv compiler
package dcdsi_pkg;
  typedef logic [13:0] dcdsi_word_t;
  typedef logic [31:0] dcdsi_data_t;
  typedef logic [7:0]  dcdsi_addr_t;
  typedef logic [1:0]  dcdsi_resp_t;
endpackage

// ### hw/dcdsi_sync.sv
// multi-bit two flip-flop level synchroniser
// assumes each bit is an independent level from outside clk's domain
module dcdsi_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rstN,
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      stage1 <= '0;
      synced <= '0;
    end
    else
    begin
      stage1 <= async;
      synced <= stage1;
    end
  end
endmodule

// ### hw/dcdsi_top.sv
// dual-channel ddr sample capture with axi4-lite config and serial pin mode
// assumes pins arrive unsynchronised; forwarded clock far slower than clk
//
// Operation
// - capture one 14-bit word on each forwarded clock edge, two per period.
// - rising-edge word is channel A, falling-edge word is channel B.
// - without bus reversal, input bit 13 is sample msb, bit 0 lsb.
// - transmit gate low forces datapath to zeros, ignoring input data.
// - sleep input high puts block to sleep; low operates normally.
// - register reset pin low asynchronously returns config to initial values.
// - serial port defaults to 3-wire, data pin carries both directions.
// - config bit 9 selects four-wire: data pin input-only, reads on out pin.
// - in 3-wire mode the dedicated serial out pin is high impedance.
// - fifo sync input captured on rising forwarded clock edge.
`include "dcdsi_consts.svh"
module dcdsi_top (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic               forwardedDataClock,
  input  wire logic [13:0]        dataBus,
  input  wire logic               transmitGate,
  input  wire logic               sleepInput,
  input  wire logic               fifoSyncInput,
  input  wire logic               registerResetN,
  input  wire logic               serialSelectN,
  input  wire logic               serialDataIn,
  output logic                    serialDataOut,
  output logic                    serialDataOe,
  output logic                    serialOutPin,
  output logic                    serialOutPinOe,
  input  wire logic               serialReadBit,
  input  wire logic               serialReadDrive,
  output logic                    serialWriteBit,
  output dcdsi_pkg::dcdsi_word_t  pairA,
  output dcdsi_pkg::dcdsi_word_t  pairB,
  output logic                    pairValid,
  output logic                    fifoSyncPulse,
  output logic                    sleepState,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output dcdsi_pkg::dcdsi_resp_t  s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output dcdsi_pkg::dcdsi_data_t  s_axi_rdata,
  output dcdsi_pkg::dcdsi_resp_t  s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready
);
  import dcdsi_pkg::*;
  function automatic dcdsi_word_t orient(input dcdsi_word_t w,
                                         input logic rev);
    dcdsi_word_t r;
    r = w;
    if (rev)
      r = {<<{w}};
    return r;
  endfunction
  // reset synchronisers: assert at once, release after two edges
  logic [1:0]  rstPipe;
  logic [1:0]  regRstPipe;
  logic        rstN;
  logic        cfgRstN;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      rstPipe <= 2'h0;
    else
      rstPipe <= {rstPipe[0], 1'b1};
  end
  always_ff @(posedge clk or negedge registerResetN)
  begin
    if (!registerResetN)
      regRstPipe <= 2'h0;
    else
      regRstPipe <= {regRstPipe[0], 1'b1};
  end
  assign rstN    = rstPipe[1];
  assign cfgRstN = rstPipe[1] & regRstPipe[1];
  // pin synchronisation
  logic [19:0] pinSync;
  logic        linkClk;
  dcdsi_word_t dataS;
  logic        gateS;
  logic        sleepS;
  logic        syncS;
  logic        selNS;
  logic        sdioS;
  dcdsi_sync #(.WIDTH(20)) i_dcdsi_sync (
    .clk    (clk),
    .rstN   (rstN),
    .async  ({forwardedDataClock, dataBus, transmitGate, sleepInput,
              fifoSyncInput, serialSelectN, serialDataIn}),
    .synced (pinSync)
  );

  assign {linkClk, dataS, gateS, sleepS, syncS, selNS, sdioS} = pinSync;

  // configuration register
  dcdsi_data_t cfgReg;
  logic        busReverse;
  logic        fourWire;
  assign busReverse = cfgReg[`DCDSI_BIT_REVERSE];
  assign fourWire   = cfgReg[`DCDSI_BIT_FOURWIRE];

  // link edge detection and capture
  logic        linkClkD;
  logic        haveA;
  dcdsi_word_t heldA;
  logic        linkRise;
  logic        linkFall;
  dcdsi_word_t gatedWord;
  dcdsi_data_t pairCount;
  assign linkRise  = linkClk & ~linkClkD;
  assign linkFall  = ~linkClk & linkClkD;
  assign gatedWord = gateS ? orient(dataS, busReverse) : '0;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      linkClkD      <= 1'b0;
      haveA         <= 1'b0;
      heldA         <= '0;
      pairA         <= '0;
      pairB         <= '0;
      pairValid     <= 1'b0;
      fifoSyncPulse <= 1'b0;
      sleepState    <= 1'b0;
      pairCount     <= '0;
    end
    else
    begin
      linkClkD      <= linkClk;
      sleepState    <= sleepS;
      pairValid     <= 1'b0;
      fifoSyncPulse <= linkRise & syncS;
      if (linkRise)
      begin
        heldA <= gatedWord;
        haveA <= ~sleepS;
      end
      if (linkFall && haveA && !sleepS)
      begin
        pairA     <= heldA;
        pairB     <= gatedWord;
        pairValid <= 1'b1;
        pairCount <= pairCount + 32'h0000_0001;
        haveA     <= 1'b0;
      end
    end
  end
  // serial pin mode steering
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      serialDataOut  <= 1'b0;
      serialDataOe   <= 1'b0;
      serialOutPin   <= 1'b0;
      serialOutPinOe <= 1'b0;
      serialWriteBit <= 1'b0;
    end
    else
    begin
      serialWriteBit <= sdioS;
      serialDataOut  <= serialReadBit;
      serialOutPin   <= serialReadBit;
      serialDataOe   <= ~fourWire & serialReadDrive & ~selNS;
      serialOutPinOe <= fourWire & serialReadDrive & ~selNS;
    end
  end
  // axi4-lite write channel
  logic        awHeld;
  logic        wHeld;
  dcdsi_addr_t awAddr;
  dcdsi_data_t wData;
  logic [3:0]  wStrb;
  logic        awTake;
  logic        wTake;
  logic        doWrite;
  logic        awHeldNext;
  logic        wHeldNext;
  logic        writeHit;
  dcdsi_data_t byteMask;
  dcdsi_data_t next_config;
  assign awTake     = s_axi_awvalid & s_axi_awready;
  assign wTake      = s_axi_wvalid & s_axi_wready;
  assign doWrite    = awHeld & wHeld & ~s_axi_bvalid;
  assign awHeldNext = (awHeld | awTake) & ~doWrite;
  assign wHeldNext  = (wHeld | wTake) & ~doWrite;
  assign writeHit   = awAddr == `DCDSI_OFF_CONFIG;
  assign byteMask   = {{8{wStrb[3]}}, {8{wStrb[2]}},
                       {8{wStrb[1]}}, {8{wStrb[0]}}}
                      & `DCDSI_CONFIG_MASK;
  assign next_config = (cfgReg & ~byteMask) | (wData & byteMask);

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      awHeld        <= 1'b0;
      wHeld         <= 1'b0;
      awAddr        <= '0;
      wData         <= '0;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `DCDSI_RESP_OKAY;
    end
    else
    begin
      awHeld        <= awHeldNext;
      wHeld         <= wHeldNext;
      s_axi_awready <= ~awHeldNext;
      s_axi_wready  <= ~wHeldNext;
      if (awTake)
        awAddr <= s_axi_awaddr;
      if (wTake)
      begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= writeHit ? `DCDSI_RESP_OKAY : `DCDSI_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  always_ff @(posedge clk or negedge cfgRstN)
  begin
    if (!cfgRstN)
      cfgReg <= `DCDSI_CONFIG_RESET;
    else if (doWrite && writeHit)
      cfgReg <= next_config;
  end
  // axi4-lite read channel
  logic        arHeld;
  dcdsi_addr_t arAddr;
  logic        arTake;
  logic        doRead;
  logic        arHeldNext;
  dcdsi_data_t statusWord;
  dcdsi_data_t readMux;
  logic        readHit;
  assign arTake     = s_axi_arvalid & s_axi_arready;
  assign doRead     = arHeld & ~s_axi_rvalid;
  assign arHeldNext = (arHeld | arTake) & ~doRead;
  assign statusWord = {29'h0, fourWire, sleepState, gateS};
  assign readHit    = arAddr == `DCDSI_OFF_CONFIG
                    || arAddr == `DCDSI_OFF_STATUS
                    || arAddr == `DCDSI_OFF_PAIR
                    || arAddr == `DCDSI_OFF_COUNT;
  assign readMux    = arAddr == `DCDSI_OFF_CONFIG ? cfgReg
                    : arAddr == `DCDSI_OFF_STATUS ? statusWord
                    : arAddr == `DCDSI_OFF_PAIR   ? {4'h0, pairB, pairA}
                    : arAddr == `DCDSI_OFF_COUNT  ? pairCount
                    : 32'h0000_0000;

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      arHeld        <= 1'b0;
      arAddr        <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= `DCDSI_RESP_OKAY;
    end
    else
    begin
      arHeld        <= arHeldNext;
      s_axi_arready <= ~arHeldNext;
      if (arTake)
        arAddr <= s_axi_araddr;
      if (doRead)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= readMux;
        s_axi_rresp  <= readHit ? `DCDSI_RESP_OKAY : `DCDSI_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ### tb/dcdsi_checker.sv
// port assertions for the sample input block
// assumes a bind onto dcdsi_top; one clock domain
module dcdsi_checker
  import dcdsi_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              fifoSyncInput,
  input wire logic              serialReadBit,
  input wire logic              serialReadDrive,
  input wire logic              serialDataOut,
  input wire logic              serialDataOe,
  input wire logic              serialOutPinOe,
  input wire dcdsi_pkg::dcdsi_word_t pairA,
  input wire dcdsi_pkg::dcdsi_word_t pairB,
  input wire logic              pairValid,
  input wire logic              fifoSyncPulse,
  input wire logic              sleepState
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_pair_pulse: assert property (pairValid |=> !pairValid)
    else $error("pair strobe longer than one cycle");
  chk_pair_hold: assert property
    (!pairValid |-> $stable(pairA) && $stable(pairB))
    else $error("pair changed without strobe");
  chk_sync_cause: assert property
    (fifoSyncPulse |-> $past(fifoSyncInput, 3))
    else $error("sync pulse without sync at rising edge");
  chk_sleep_quiet: assert property (sleepState |-> !pairValid)
    else $error("pair produced while asleep");
  chk_pin_excl: assert property (serialOutPinOe |-> !serialDataOe)
    else $error("both serial pins driven");
  chk_oe_cause: assert property
    (serialDataOe |-> $past(serialReadDrive))
    else $error("data pin driven without read drive");
  chk_out_follow: assert property
    (serialDataOe |-> serialDataOut == $past(serialReadBit))
    else $error("data pin value not the read bit");
  chk_outpin_cause: assert property
    (serialOutPinOe |-> $past(serialReadDrive))
    else $error("out pin driven without read drive");
endmodule

bind dcdsi_top dcdsi_checker i_dcdsi_checker (.*);

// ### tb/dcdsi_host.sv
// host model driving the ddr sample bus and forwarded clock
// assumes clk is the block clock; link clock idles low between frames
module dcdsi_host (
  input wire logic          clk,
  output logic              forwardedDataClock,
  output dcdsi_pkg::dcdsi_word_t dataBus,
  output logic              fifoSyncInput
);
  timeunit 1ns;
  timeprecision 1ps;
  import dcdsi_pkg::*;
  initial
  begin
    forwardedDataClock = 1'b0;
    dataBus = 14'h0000;
    fifoSyncInput = 1'b0;
  end
  // word a centred on the rise, word b on the fall
  task automatic send(input dcdsi_word_t a, b, input logic s);
  begin
    @(posedge clk);
    dataBus <= a;
    fifoSyncInput <= s;
    repeat (4) @(posedge clk);
    forwardedDataClock <= 1'b1;
    repeat (4) @(posedge clk);
    dataBus <= b;
    fifoSyncInput <= 1'b0;
    repeat (4) @(posedge clk);
    forwardedDataClock <= 1'b0;
    repeat (4) @(posedge clk);
    dataBus <= ~b;
  end
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the sample input block
// assumes dcdsi_top, dcdsi_host and the checker compiled before
`include "dcdsi_consts.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dcdsi_pkg::*;
  logic        clk, resetn, transmitGate, sleepInput, registerResetN;
  logic        serialSelectN, serialDataIn, serialReadBit, serialReadDrive;
  logic        serialDataOut, serialDataOe, serialOutPin, serialOutPinOe;
  logic        serialWriteBit, pairValid, fifoSyncPulse, sleepState;
  logic        forwardedDataClock, fifoSyncInput;
  dcdsi_word_t dataBus, pairA, pairB;
  dcdsi_addr_t s_axi_awaddr, s_axi_araddr;
  dcdsi_data_t s_axi_wdata, s_axi_rdata, rd;
  dcdsi_resp_t s_axi_bresp, s_axi_rresp, rs;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          err_count, checks, pairCnt, syncCnt;
  dcdsi_top i_dcdsi_top (.*);
  dcdsi_host i_dcdsi_host (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (pairValid === 1'b1) pairCnt++;
    if (fifoSyncPulse === 1'b1) syncCnt++;
  end
  task automatic close_out;
  begin
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask
  task automatic cmp(input string n, input logic [31:0] e, g);
  begin
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  end
  endtask
  task automatic axi_wr(input dcdsi_addr_t a, input dcdsi_data_t d);
    int i;
  begin
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    rs = s_axi_bresp;
    if (i == 50)
    begin
      cmp("bvalid", 1, 0);
      close_out();
    end
  end
  endtask
  task automatic axi_rd(input dcdsi_addr_t a);
    int i;
  begin
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++)
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    if (i == 50)
    begin
      cmp("rvalid", 1, 0);
      close_out();
    end
  end
  endtask
  task automatic frame(input dcdsi_word_t a, b, input logic s, input int w);
    int i;
  begin
    i_dcdsi_host.send(a, b, s);
    for (i = 0; i < 30 && pairCnt != w; i++) @(posedge clk);
    cmp("pairs", w, pairCnt);
    if (pairCnt != w) close_out();
  end
  endtask
  task automatic sc_regs;
  begin
    axi_rd(`DCDSI_OFF_CONFIG);
    cmp("cfg", 0, rd);
    cmp("pins", 32'h2, {29'h0, serialOutPinOe, serialDataOe, 1'b0});
    axi_wr(`DCDSI_OFF_CONFIG, 32'hFFFF_FFFF);
    axi_rd(`DCDSI_OFF_CONFIG);
    cmp("cfg", 32'h201, rd);
    axi_wr(`DCDSI_OFF_STATUS, 32'h0);
    cmp("bresp", `DCDSI_RESP_SLVERR, rs);
    axi_rd(8'h10);
    cmp("rresp", `DCDSI_RESP_SLVERR, rs);
    repeat (6) @(posedge clk);
    cmp("io", 5, {29'h0, serialOutPinOe, serialDataOe, serialOutPin});
    registerResetN <= 1'b0;
    repeat (2) @(posedge clk);
    registerResetN <= 1'b1;
    repeat (6) @(posedge clk);
    axi_rd(`DCDSI_OFF_CONFIG);
    cmp("cfg", 0, rd);
    cmp("io", 7, {29'h0, serialDataOe, serialDataOut, serialWriteBit});
    serialReadBit <= 1'b0;
    serialDataIn <= 1'b0;
    repeat (6) @(posedge clk);
    cmp("io", 4, {29'h0, serialDataOe, serialDataOut, serialWriteBit});
    serialSelectN <= 1'b1;
    repeat (6) @(posedge clk);
    cmp("desel", 0, {30'h0, serialOutPinOe, serialDataOe});
    {serialSelectN, serialReadBit, serialDataIn} <= 3'h3;
    repeat (6) @(posedge clk);
  end
  endtask
  task automatic sc_link;
  begin
    frame(14'h2005, 14'h0A3C, 1'b1, 1);
    cmp("pair", {4'h0, 14'h0A3C, 14'h2005}, {4'h0, pairB, pairA});
    cmp("syncs", 1, syncCnt);
    frame(14'h1555, 14'h3FFF, 1'b0, 2);
    cmp("syncs", 1, syncCnt);
    axi_rd(`DCDSI_OFF_PAIR);
    cmp("pairReg", {4'h0, 14'h3FFF, 14'h1555}, rd);
    axi_rd(`DCDSI_OFF_COUNT);
    cmp("count", 2, rd);
  end
  endtask
  task automatic sc_rev;
  begin
    axi_wr(`DCDSI_OFF_CONFIG, 32'h1);
    frame(14'h2005, 14'h0A3C, 1'b0, 3);
    cmp("revPair", {4'h0, 14'h0F14, 14'h2801}, {4'h0, pairB, pairA});
    axi_wr(`DCDSI_OFF_CONFIG, 32'h0);
  end
  endtask
  task automatic sc_gate_sleep;
  begin
    transmitGate <= 1'b0;
    frame(14'h3FFF, 14'h2AAA, 1'b0, 4);
    cmp("gated", 0, {4'h0, pairB, pairA});
    transmitGate <= 1'b1;
    sleepInput <= 1'b1;
    frame(14'h0123, 14'h0456, 1'b0, 4);
    cmp("sleep", 1, sleepState);
    axi_rd(`DCDSI_OFF_STATUS);
    cmp("status", 32'h3, rd);
    sleepInput <= 1'b0;
    repeat (6) @(posedge clk);
    frame(14'h0123, 14'h0456, 1'b0, 5);
    cmp("wake", {4'h0, 14'h0456, 14'h0123}, {4'h0, pairB, pairA});
  end
  endtask
  initial
  begin
    {resetn, sleepInput, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 0;
    {s_axi_arvalid, s_axi_rready, serialSelectN} = 0;
    {transmitGate, registerResetN, serialDataIn} = 3'h7;
    {serialReadBit, serialReadDrive} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    s_axi_wstrb = 4'hF;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    repeat (8) @(posedge clk);
    sc_regs();
    sc_link();
    sc_rev();
    sc_gate_sleep();
    close_out();
  end
endmodule
